//--- btp_boundary_scan_test_port.sv
// boundary-scan test access port sampled on the system clock
`timescale 1ns/1ns

// Behaviour
// - io standard chain accepts updates before configuration or in user mode.
// - pll bits sit in the chain while unconfigured, leave it afterwards.
// - sample captures pin values undisturbed and preloads an output pattern.
// - extest drives outputs from the scan cells and captures inputs.
// - bypass puts a one-bit register between tdi and tdo.
// - highz selects bypass and floats every io pin.
// - clamp selects bypass and holds pins at the scan cell values.
// - user code instruction shifts a 32-bit user code out on tdo.
// - ident instruction shifts the identification value out on tdo.
// - ident is version, part number, maker and a single low bit.
// - instruction register is 10 bits, user code register 32 bits.
// - boundary register length is 1029, 1665 or 1941 cells per variant.
// - pulse reconfig acts like a low pulse on the restart pin.
// - config io programs io standards, aborting configuration in progress.
// - pull-ups and bus hold override float during highz, clamp, extest.
// - in-circuit reconfig lets configuration bits arrive through the port.
// - outputs stay undriven until configured unless extest or clamp drives them, then follow user logic outside test modes.
// - lowest ident bit is always one, listed most significant first.
// - pins float with weak pull-ups until configuration ends.
module btp_boundary_scan_test_port
  import btp_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_SMALL, // boundary cells of this variant
  localparam int PIN_N = BSR_LEN / CELLS_PER_PIN,
  localparam int IOSTD_LEN = PIN_N * IOSTD_BITS
) (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, high
  input wire btp_jtag_t jtagPins, // tck, tms, tdi from pins
  output logic tdo_q, // serial data out
  output logic tdoOe_q, // tdo driven while shifting
  input wire logic configDone, // device in user mode
  input wire logic configBusy, // configuration in progress
  input wire logic [ID_W-1:0] user_defined_code, // code from the configuration
  input wire logic [PIN_N-1:0] coreOut, // user logic pin values
  input wire logic [PIN_N-1:0] coreOe, // user logic pin enables
  input wire logic [PIN_N-1:0] pullEn, // bus hold or pull-up chosen
  input wire logic [PIN_N-1:0] pinIn, // level seen on each pin
  output logic [PIN_N-1:0] pinOut_q, // pin output value
  output logic [PIN_N-1:0] pinOe_q, // pin output enable
  output logic [PIN_N-1:0] pinPull_q, // weak pull-up active
  output logic [IOSTD_LEN-1:0] ioStd_q, // io element standard bits
  output logic ioStdLoad_q, // pulse: new standards loaded
  output logic [PLL_LEN-1:0] pllCfg_q, // pll reconfiguration bits
  output logic reconfigPulse_q, // pulse: restart configuration
  output logic configAbort_q, // pulse: stop running configuration
  output logic cfgBit_q, // configuration bit from the port
  output logic cfgBitValid_q // pulse: cfgBit_q is new
);

  // ************************************************************
  // input synchronisers and tck edge detection
  // ************************************************************
  btp_jtag_t jtagS1;
  btp_jtag_t jtagS2;
  logic tckPrev;
  logic [PIN_N-1:0] pinS1;
  logic [PIN_N-1:0] pinS2;
  logic tckRise;
  logic tckFall;
  logic tdi;

  // two flops on every pin input before use
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      jtagS1 <= '0;
      jtagS2 <= '0;
      tckPrev <= 1'h0;
      pinS1 <= '0;
      pinS2 <= '0;
    end else begin
      jtagS1 <= jtagPins;
      jtagS2 <= jtagS1;
      tckPrev <= jtagS2.tck;
      pinS1 <= pinIn;
      pinS2 <= pinS1;
    end
  end

  assign tckRise = jtagS2.tck & ~tckPrev;
  assign tckFall = ~jtagS2.tck & tckPrev;
  assign tdi = jtagS2.tdi;

  // ************************************************************
  // tap controller
  // ************************************************************
  btp_tap_t state_q;

  // next tap state for a given tms level
  function automatic btp_tap_t tapNext(btp_tap_t s, logic m);
    btp_tap_t n;
    n = TAP_RESET;
    unique case (s)
      TAP_RESET: n = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: n = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: n = m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: n = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: n = m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: n = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: n = m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: n = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: n = m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
      default: n = TAP_RESET;
    endcase
    return n;
  endfunction

  // advance on each rising tck
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= TAP_RESET;
    end else if (tckRise) begin
      state_q <= tapNext(state_q, jtagS2.tms);
    end
  end

  // ************************************************************
  // instruction register and decode
  // ************************************************************
  logic [IR_W-1:0] irShift_q;
  logic [IR_W-1:0] ir_q;
  logic isExtest;
  logic isSample;
  logic isHighz;
  logic isClamp;
  logic isUser;
  logic isIdent;
  logic isCfgIo;
  logic isInCircuit;
  logic pllInChain;
  logic drShift;
  logic drCapture;
  logic drUpdate;

  // capture, shift and update of the 10-bit instruction
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irShift_q <= '0;
      ir_q <= OP_IDENT;
    end else if (tckRise) begin
      if (state_q == TAP_RESET) begin
        ir_q <= OP_IDENT;
      end
      if (state_q == TAP_CAP_IR) begin
        irShift_q <= IR_CAPTURE;
      end
      if (state_q == TAP_SHIFT_IR) begin
        irShift_q <= {tdi, irShift_q[IR_W-1:1]};
      end
      if (state_q == TAP_UPD_IR) begin
        ir_q <= irShift_q;
      end
    end
  end

  // anything not decoded here falls back to bypass
  assign isExtest = (ir_q == OP_EXTEST);
  assign isSample = (ir_q == OP_SAMPLE);
  assign isHighz = (ir_q == OP_HIGHZ);
  assign isClamp = (ir_q == OP_CLAMP);
  assign isUser = (ir_q == OP_USER);
  assign isIdent = (ir_q == OP_IDENT);
  assign isCfgIo = (ir_q == OP_CONFIG_IO);
  assign isInCircuit = (ir_q == OP_IN_CIRCUIT_RECONFIG);
  assign pllInChain = ~configDone & (isExtest | isSample);
  assign drShift = tckRise & (state_q == TAP_SHIFT_DR);
  assign drCapture = tckRise & (state_q == TAP_CAP_DR);
  assign drUpdate = tckRise & (state_q == TAP_UPD_DR);

  // ************************************************************
  // boundary register with its update stage
  // ************************************************************
  logic [BSR_LEN-1:0] bsr_q;
  logic [BSR_LEN-1:0] bsrUpd_q;

  // cells per pin: input, output, enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bsr_q <= '0;
      bsrUpd_q <= '0;
    end else if (isExtest | isSample) begin
      if (drCapture) begin
        for (int k = 0; k < PIN_N; k++) begin
          bsr_q[k*CELLS_PER_PIN+CELL_IN] <= pinS2[k];
          bsr_q[k*CELLS_PER_PIN+CELL_OUT] <= pinOut_q[k];
          bsr_q[k*CELLS_PER_PIN+CELL_OE] <= pinOe_q[k];
        end
      end
      if (drShift) begin
        bsr_q <= {tdi, bsr_q[BSR_LEN-1:1]};
      end
      if (drUpdate) begin
        bsrUpd_q <= bsr_q; // preload or extest pattern
      end
    end
  end

  // ************************************************************
  // pll reconfiguration bits behind the boundary cells
  // ************************************************************
  logic [PLL_LEN-1:0] pll_q;

  // only part of the chain before configuration
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pll_q <= '0;
      pllCfg_q <= '0;
    end else if (pllInChain) begin
      if (drCapture) begin
        pll_q <= pllCfg_q;
      end
      if (drShift) begin
        pll_q <= {bsr_q[0], pll_q[PLL_LEN-1:1]};
      end
      if (drUpdate) begin
        pllCfg_q <= pll_q;
      end
    end
  end

  // ************************************************************
  // identification, user code and bypass registers
  // ************************************************************
  logic [ID_W-1:0] id_q;
  logic bypass_q;
  logic [ID_W-1:0] identValue;

  assign identValue = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};

  // one shifter serves ident and user code
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      id_q <= '0;
    end else if (isIdent | isUser) begin
      if (drCapture) begin
        id_q <= isIdent ? identValue : user_defined_code;
      end
      if (drShift) begin
        id_q <= {tdi, id_q[ID_W-1:1]};
      end
    end
  end

  // single stage, captures zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bypass_q <= 1'h0;
    end else if (drCapture) begin
      bypass_q <= 1'h0;
    end else if (drShift) begin
      bypass_q <= tdi;
    end
  end

  // ************************************************************
  // io standard chain and configuration strobes
  // ************************************************************
  logic [IOSTD_LEN-1:0] ioShift_q;
  logic irUpdate;

  assign irUpdate = tckRise & (state_q == TAP_UPD_IR);

  // io standards load whenever the instruction is active
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ioShift_q <= '0;
      ioStd_q <= '0;
      ioStdLoad_q <= 1'h0;
    end else begin
      ioStdLoad_q <= 1'h0;
      if (isCfgIo & drCapture) begin
        ioShift_q <= ioStd_q;
      end
      if (isCfgIo & drShift) begin
        ioShift_q <= {tdi, ioShift_q[IOSTD_LEN-1:1]};
      end
      if (isCfgIo & drUpdate) begin
        ioStd_q <= ioShift_q;
        ioStdLoad_q <= 1'h1;
      end
    end
  end

  // one-cycle strobes toward the configuration logic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reconfigPulse_q <= 1'h0;
      configAbort_q <= 1'h0;
      cfgBit_q <= 1'h0;
      cfgBitValid_q <= 1'h0;
    end else begin
      reconfigPulse_q <= irUpdate & (irShift_q == OP_PULSE_RECONFIG);
      configAbort_q <= irUpdate & (irShift_q == OP_CONFIG_IO)
                       & configBusy;
      cfgBitValid_q <= isInCircuit & drShift;
      if (isInCircuit & drShift) begin
        cfgBit_q <= tdi;
      end
    end
  end

  // ************************************************************
  // serial output
  // ************************************************************
  logic serialOut;

  // pick the low bit of the selected register
  always_comb begin
    serialOut = bypass_q;
    if (state_q == TAP_SHIFT_IR) begin
      serialOut = irShift_q[0];
    end else if (pllInChain) begin
      serialOut = pll_q[0];
    end else if (isExtest | isSample) begin
      serialOut = bsr_q[0];
    end else if (isIdent | isUser) begin
      serialOut = id_q[0];
    end else if (isCfgIo) begin
      serialOut = ioShift_q[0];
    end
  end

  // tdo changes on falling tck only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tdo_q <= 1'h0;
      tdoOe_q <= 1'h0;
    end else if (tckFall) begin
      tdo_q <= serialOut;
      tdoOe_q <= (state_q == TAP_SHIFT_IR) | (state_q == TAP_SHIFT_DR);
    end
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  logic testDrive;
  logic testFloat;

  assign testDrive = isExtest | isClamp;
  assign testFloat = testDrive | isHighz;

  // test modes win, then user logic once configured
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinOut_q <= '0;
      pinOe_q <= '0;
      pinPull_q <= '1;
    end else begin
      for (int k = 0; k < PIN_N; k++) begin
        if (isHighz) begin
          pinOut_q[k] <= 1'h0;
          pinOe_q[k] <= 1'h0;
        end else if (testDrive) begin
          pinOut_q[k] <= bsrUpd_q[k*CELLS_PER_PIN+CELL_OUT];
          pinOe_q[k] <= bsrUpd_q[k*CELLS_PER_PIN+CELL_OE];
        end else if (configDone) begin
          pinOut_q[k] <= coreOut[k];
          pinOe_q[k] <= coreOe[k];
        end else begin
          pinOut_q[k] <= 1'h0;
          pinOe_q[k] <= 1'h0;
        end
        pinPull_q[k] <= ~configDone | (testFloat & pullEn[k]);
      end
    end
  end

endmodule

//--- btp_pkg.sv
// shared constants, opcodes and types of the boundary-scan test port
package btp_pkg;

  // ************************************************************
  // chain lengths and cell layout
  // ************************************************************
  localparam int BSR_LEN_SMALL = 1029;
  localparam int BSR_LEN_MID = 1665;
  localparam int BSR_LEN_LARGE = 1941;
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int IR_W = 10;
  localparam int ID_W = 32;
  localparam int PLL_LEN = 16;
  localparam int IOSTD_BITS = 2;

  // ************************************************************
  // instruction opcodes
  // ************************************************************
  localparam logic [IR_W-1:0] OP_EXTEST = 10'h000;
  localparam logic [IR_W-1:0] OP_PULSE_RECONFIG = 10'h001;
  localparam logic [IR_W-1:0] OP_IN_CIRCUIT_RECONFIG = 10'h002;
  localparam logic [IR_W-1:0] OP_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] OP_IDENT = 10'h006;
  localparam logic [IR_W-1:0] OP_USER = 10'h007;
  localparam logic [IR_W-1:0] OP_CLAMP = 10'h00A;
  localparam logic [IR_W-1:0] OP_HIGHZ = 10'h00B;
  localparam logic [IR_W-1:0] OP_CONFIG_IO = 10'h00D;
  localparam logic [IR_W-1:0] OP_BYPASS = 10'h3FF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;

  // ************************************************************
  // identification fields (values arbitrary)
  // ************************************************************
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h5A5A;
  localparam logic [10:0] ID_MAKER = 11'h2A5;
  localparam logic ID_LSB = 1'h1;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } btp_jtag_t;

  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } btp_tap_t;

endpackage

//--- btp_checker_sva.sv
// concurrent checks on the boundary-scan test port outputs
`timescale 1ns/1ns
module btp_checker_sva
  import btp_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_SMALL // boundary cells of this variant
) (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, high
  input wire btp_jtag_t jtagPins, // raw tck, tms, tdi
  input wire logic tdo_q, // serial data out
  input wire logic tdoOe_q, // tdo driver enable
  input wire logic configDone, // user mode
  input wire logic configBusy, // configuration running
  input wire logic [BSR_LEN/CELLS_PER_PIN-1:0] pullEn, // pull chosen
  input wire logic [BSR_LEN/CELLS_PER_PIN-1:0] pinPull_q, // pull active
  input wire logic ioStdLoad_q, // standards loaded pulse
  input wire logic reconfigPulse_q, // restart pulse
  input wire logic configAbort_q, // abort pulse
  input wire logic cfgBitValid_q // new configuration bit
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ************************************************************
  // pulses, pulls and tdo timing
  // ************************************************************
  a_recfg_one_cycle: assert property (reconfigPulse_q |=> !reconfigPulse_q)
    else $error("restart pulse too long");
  a_abort_one_cycle: assert property (configAbort_q |=> !configAbort_q)
    else $error("abort pulse too long");
  a_abort_needs_busy: assert property (configAbort_q |-> $past(configBusy))
    else $error("abort without running configuration");
  a_load_one_cycle: assert property (ioStdLoad_q |=> !ioStdLoad_q)
    else $error("standard load pulse too long");
  a_bit_one_cycle: assert property (cfgBitValid_q |=> !cfgBitValid_q)
    else $error("configuration bit pulse too long");
  a_pull_unconfigured: assert property (!configDone |=> &pinPull_q)
    else $error("pull-up missing before configuration");
  a_pull_only_enabled: assert property (configDone |=>
    (pinPull_q & ~$past(pullEn)) == '0)
    else $error("pull active on a pin without pull");
  // tdo and its enable move only after a falling tck edge
  a_tdo_on_fall: assert property ($changed(tdo_q) |->
    !$past(jtagPins.tck, 2) && !$past(jtagPins.tck, 3))
    else $error("tdo changed away from a tck fall");
  a_oe_on_fall: assert property ($changed(tdoOe_q) |->
    !$past(jtagPins.tck, 2) && !$past(jtagPins.tck, 3))
    else $error("tdo enable changed away from a tck fall");
endmodule

bind btp_boundary_scan_test_port btp_checker_sva #(.BSR_LEN(BSR_LEN)) u_chk (
  .mclk, .rst, .jtagPins, .tdo_q, .tdoOe_q, .configDone, .configBusy,
  .pullEn, .pinPull_q, .ioStdLoad_q, .reconfigPulse_q, .configAbort_q,
  .cfgBitValid_q
);

//--- btp_jtag_host.sv
// model of the external test controller on tck, tms and tdi
`timescale 1ns/1ns
module btp_jtag_host
  import btp_pkg::*;
(
  input wire logic mclk, // system clock, paces the edges
  input wire logic tdo, // serial data from the port
  output btp_jtag_t pins // tck, tms, tdi to the port
);
  // tck rests low between frames
  initial begin
    pins = '0;
  end
  // one tck period of 160 ns, tdo taken just before the fall
  task automatic tick(input logic tms, input logic tdi, input logic dv,
    output logic so);
    pins.tms = tms;
    pins.tdi = dv ? tdi : ~pins.tdi; // unused tdi keeps toggling
    repeat (4) @(posedge mclk);
    #1 pins.tck = 1'b1;
    repeat (4) @(posedge mclk);
    #1 so = tdo;
    pins.tck = 1'b0;
  endtask
  // five high tms bits force test-logic-reset, then idle
  task automatic reset_tap();
    logic b;
    repeat (5) tick(1'b1, 1'b0, 1'b0, b);
    tick(1'b0, 1'b0, 1'b0, b);
  endtask
  // idle to idle scan of n bits, lsb first, update on the way out
  task automatic scan(input logic ir, input int n, input logic [2047:0] din,
    output logic [2047:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b0, 1'b0, b);
    if (ir) tick(1'b1, 1'b0, 1'b0, b);
    tick(1'b0, 1'b0, 1'b0, b);
    tick(1'b0, 1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], 1'b1, b);
      dout[i] = b;
    end
    tick(1'b1, 1'b0, 1'b0, b);
    tick(1'b0, 1'b0, 1'b0, b);
  endtask
endmodule

//--- btp_boundary_scan_test_port_bench.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
module btp_boundary_scan_test_port_bench;
  import btp_pkg::*;
  localparam int BL = BSR_LEN_SMALL;
  localparam int PN = BL / CELLS_PER_PIN;
  localparam int IL = PN * IOSTD_BITS;
  logic mclk, rst, tdo_q, tdoOe_q, configDone, configBusy;
  logic [ID_W-1:0] user_defined_code;
  logic [PN-1:0] coreOut, coreOe, pullEn, pinIn, extLvl, pinOut_q, pinOe_q;
  logic [PN-1:0] pinPull_q, outP, oeP;
  logic [IL-1:0] ioStd_q;
  logic ioStdLoad_q, reconfigPulse_q, configAbort_q, cfgBit_q, cfgBitValid_q;
  logic [PLL_LEN-1:0] pllCfg_q;
  btp_jtag_t jtagPins;
  logic [2047:0] dOut, pat;
  logic [7:0] cfgSeq;
  logic [IR_W-1:0] byOps [4] = '{OP_BYPASS, 10'h155, OP_HIGHZ, OP_CLAMP};
  int fails, n_tests, nRecfg, nAbort, nLoad, nValid, nOe;
  // pin level: driven by the port or by the board
  assign pinIn = (pinOe_q & pinOut_q) | (~pinOe_q & extLvl);
  // free-running system clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  btp_boundary_scan_test_port #(.BSR_LEN(BL)) i_btp_boundary_scan_test_port (
    .mclk, .rst, .jtagPins, .tdo_q, .tdoOe_q, .configDone, .configBusy,
    .user_defined_code, .coreOut, .coreOe, .pullEn, .pinIn, .pinOut_q, .pinOe_q,
    .pinPull_q, .ioStd_q, .ioStdLoad_q, .pllCfg_q, .reconfigPulse_q,
    .configAbort_q, .cfgBit_q, .cfgBitValid_q);
  btp_jtag_host i_btp_jtag_host (.mclk, .tdo(tdo_q), .pins(jtagPins));
  // count pulses and gather configuration bits
  always @(posedge mclk) begin
    if (reconfigPulse_q === 1'b1) nRecfg++;
    if (configAbort_q === 1'b1) nAbort++;
    if (ioStdLoad_q === 1'b1) nLoad++;
    if (tdoOe_q === 1'b1) nOe++;
    if (cfgBitValid_q === 1'b1) begin
      nValid++;
      cfgSeq = {cfgBit_q, cfgSeq[7:1]};
    end
  end
  // ************************************************************
  // compare, report and access tasks
  // ************************************************************
  task automatic check_vec(input string what, input logic [2047:0] exp,
    input logic [2047:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic check_cnt(input string what, input int exp, input int got);
    check_vec(what, exp, got);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic load_ir(input logic [IR_W-1:0] op);
    i_btp_jtag_host.scan(1'b1, IR_W, op, dOut);
    check_vec("ir capture", IR_CAPTURE, dOut[IR_W-1:0]);
  endtask
  task automatic dr(input int n, input logic [2047:0] din);
    i_btp_jtag_host.scan(1'b0, n, din, dOut);
  endtask
  // one cell kind of every pin out of a chain image
  function automatic logic [PN-1:0] cells(input logic [2047:0] v, input int c);
    for (int k = 0; k < PN; k++) cells[k] = v[CELLS_PER_PIN * k + c];
  endfunction
  // hang guard
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    print_verdict();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {configDone, configBusy, nRecfg, nAbort, nLoad, nValid, nOe} = 0;
    rst = 1'b1;
    {fails, n_tests, cfgSeq} = 0;
    user_defined_code = 32'hC3A51E0F;
    for (int k = 0; k < PN; k++) begin
      {coreOut[k], coreOe[k], pullEn[k]} = k[2:0];
      extLvl[k] = k[0] ^ k[3];
    end
    pat = '0;
    for (int i = 0; i < 1100; i++) pat[i] = i[0] ^ i[2] ^ i[4];
    outP = cells(pat, CELL_OUT);
    oeP = cells(pat, CELL_OE);
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    i_btp_jtag_host.reset_tap();
    dr(ID_W, '0);
    check_vec("ident", {ID_VERSION, ID_PART, ID_MAKER, ID_LSB}, dOut);
    check_vec("unconfigured oe", '0, pinOe_q);
    load_ir(OP_USER);
    dr(ID_W, '0);
    check_vec("user code", user_defined_code, dOut);
    configDone = 1'b1;
    load_ir(OP_SAMPLE);
    check_vec("sample out", coreOut, pinOut_q);
    dr(BL, pat);
    check_vec("sample in", coreOe & coreOut | ~coreOe & extLvl,
      cells(dOut, CELL_IN));
    load_ir(OP_EXTEST);
    check_vec("extest out", outP, pinOut_q);
    check_vec("extest oe", oeP, pinOe_q);
    check_vec("extest pull", pullEn, pinPull_q);
    dr(BL, pat);
    check_vec("extest in", oeP & outP | ~oeP & extLvl, cells(dOut, CELL_IN));
    foreach (byOps[j]) begin
      load_ir(byOps[j]);
      nOe = 0;
      dr(2, 2'b11);
      check_vec("bypass", 2'b10, dOut);
      // two shift ticks of eight system clocks each
      check_cnt("tdo enable cycles", 16, nOe);
      check_vec("oe", byOps[j] == OP_HIGHZ ? '0 :
        byOps[j] == OP_CLAMP ? oeP : coreOe, pinOe_q);
      check_vec("pull", byOps[j] >= OP_CLAMP && byOps[j] <= OP_HIGHZ ?
        pullEn : '0, pinPull_q);
    end
    load_ir(OP_PULSE_RECONFIG);
    check_cnt("restart pulses", 1, nRecfg);
    {configDone, configBusy} = 2'b01;
    load_ir(OP_CONFIG_IO);
    check_cnt("abort pulses", 1, nAbort);
    configBusy = 1'b0;
    load_ir(OP_CONFIG_IO);
    check_cnt("abort when idle", 1, nAbort);
    dr(IL, pat);
    check_vec("io standard", pat[IL-1:0], ioStd_q);
    check_cnt("standard loads", 1, nLoad);
    load_ir(OP_SAMPLE);
    dr(BL + PLL_LEN, pat);
    check_vec("pll bits", pat[PLL_LEN-1:0], pllCfg_q);
    check_vec("float oe", '0, pinOe_q);
    check_vec("float pull", {PN{1'b1}}, pinPull_q);
    configDone = 1'b1;
    dr(BL + PLL_LEN, ~pat);
    check_vec("pll kept", pat[PLL_LEN-1:0], pllCfg_q);
    load_ir(OP_IN_CIRCUIT_RECONFIG);
    dr(8, 8'hA5);
    check_vec("config bits", 8'hA5, cfgSeq);
    check_cnt("config bit pulses", 8, nValid);
    print_verdict();
  end
endmodule
